// ===== usf_pkg.sv
// Constants and carrier types of the USB status and flag unit.
//
// Behaviour
// - Six on-the-go inputs readable at bits 5..0.
// - Receive data, D-minus, D-plus readable at 6..4.
// - Bits 3,2 drive SE0 request and transmit data.
// - Bit 1 drives active-low transmit enable, resets 1.
// - Bit 0 selects serial interface mode, resets 0.
// - Non-held event flags 6 and 2 clear when next packet begins.
// - Flag 6 set on correctly decoded addressed token.
// - Flags 5,4,3 set on SE0, K, J line states.
// - Flag 2 set on data CRC16 failure.
// - Flags 1,0 follow receive-active and receive-error.
// - Held flags keep value until software writes 1.
// - Non-held level flags overwritten by signal; hold bits reset 0.
// - Four byte masks OR selected flags onto ports.
// - Eleven-bit frame counter, readable and writable, resets 0.
// - Last received packet identifier captured in bits 3:0.
// - Last endpoint in 3:0, valid marker at bit 4.
// - Special endpoint mask ORs 0x10 onto delivered endpoint.
// - Any write to reset register restores software-visible state and clears endpoint port.
package usf_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses of 32-bit words).
  // ---------------------------------------------------------------------
  localparam logic [7:0] USF_OFS_RESET = 8'h00;
  localparam logic [7:0] USF_OFS_OTG_STATUS = 8'h14;
  localparam logic [7:0] USF_OFS_SERIAL = 8'h18;
  localparam logic [7:0] USF_OFS_FLAGS = 8'h1c;
  localparam logic [7:0] USF_OFS_HOLD = 8'h20;
  localparam logic [7:0] USF_OFS_MASKS = 8'h24;
  localparam logic [7:0] USF_OFS_FRAME = 8'h28;
  localparam logic [7:0] USF_OFS_PID = 8'h2c;
  localparam logic [7:0] USF_OFS_ENDPOINT = 8'h30;
  localparam logic [7:0] USF_OFS_SPECIAL = 8'h34;
  localparam logic [7:0] USF_OFS_OTG_MASK = 8'h38;
  localparam logic [7:0] USF_OFS_PWRSIG = 8'h3c;

  // ---------------------------------------------------------------------
  // Field widths, positions and reset values.
  // ---------------------------------------------------------------------
  localparam int USF_FLAG_W = 7;
  localparam int USF_SER_CTL_W = 4;
  localparam logic [3:0] USF_SER_CTL_RESET = 4'h2;
  localparam int USF_SER_TXSE0 = 3;
  localparam int USF_SER_TXDAT = 2;
  localparam int USF_SER_TXENN = 1;
  localparam int USF_SER_FSLS = 0;
  localparam int USF_FLG_TOKEN = 6;
  localparam int USF_FLG_SE0 = 5;
  localparam int USF_FLG_K = 4;
  localparam int USF_FLG_J = 3;
  localparam int USF_FLG_CRC16 = 2;
  localparam int USF_FLG_RXACT = 1;
  localparam int USF_FLG_RXERR = 0;
  // Level flags; the rest are set by events.
  localparam logic [6:0] USF_FLG_LEVEL = 7'h3b;
  localparam int USF_MSK_N_LSB = 0;
  localparam int USF_MSK_O_LSB = 8;
  localparam int USF_MSK_P_LSB = 16;
  localparam int USF_MSK_Q_LSB = 24;
  localparam int USF_FRAME_W = 11;
  localparam int USF_ENDP_VALID = 4;
  localparam logic [4:0] USF_SPECIAL_OR = 5'h10;
  localparam int USF_PWRSIG_W = 9;
  // Line state codes of the transceiver.
  localparam logic [1:0] USF_LS_SE0 = 2'h0;
  localparam logic [1:0] USF_LS_J = 2'h1;
  localparam logic [1:0] USF_LS_K = 2'h2;
  // Start-of-frame token identifier.
  localparam logic [3:0] USF_PID_SOF = 4'h5;

  // ---------------------------------------------------------------------
  // Carrier types.
  // ---------------------------------------------------------------------
  // On-the-go inputs in status word order.
  typedef struct packed {
    logic bvalid;
    logic idgnd;
    logic hostdis;
    logic vbusvld;
    logic sessvld;
    logic sessend;
  } usf_otg_type;

  // Received token.
  typedef struct packed {
    logic [7:0] pid;
    logic [10:0] field;
    logic [4:0] crc5;
  } usf_token_type;

  // One register access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } usf_bus_req_type;

  // Software-visible state.
  typedef struct packed {
    logic [3:0] ser_ctl;
    logic [6:0] flags;
    logic [6:0] hold;
    logic [31:0] masks;
    logic [10:0] frame;
    logic [3:0] pid;
    logic [3:0] endp;
    logic endp_valid;
    logic [15:0] special;
    logic [31:0] otg_mask;
    logic [8:0] pwrsig;
  } usf_regs_type;

  localparam usf_regs_type USF_REGS_RESET = '{
    ser_ctl: USF_SER_CTL_RESET, flags: 7'h00, hold: 7'h00, masks: 32'h0000_0000,
    frame: 11'h000, pid: 4'h0, endp: 4'h0, endp_valid: 1'b0, special: 16'h0000,
    otg_mask: 32'h0000_0000, pwrsig: 9'h000};

  // True when any flag selected by a mask byte is high.
  function automatic logic usf_any_flag(input logic [6:0] flags, input logic [7:0] mask);
    return |(flags & mask[6:0]);
  endfunction : usf_any_flag

endpackage : usf_pkg

// ===== usf_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps

module usf_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Asynchronous inputs and their synchronised copy.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second.
  logic [WIDTH-1:0] sync_reg; // Second stage, safe to use.

  // --------------------------------------------------------------------
  // Both stages clear on reset.
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule : usf_sync2

// ===== usf_token_check.sv
// Token checker: PID check, CRC5 check and device address match.
`timescale 1ns/1ps

module usf_token_check
  import usf_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Token and programmed address.
  input wire usf_token_type token_i,
  input wire logic token_valid_i,
  input wire logic [6:0] dev_addr_i,
  // Registered result.
  output logic good_o,
  output logic sof_o,
  output logic [3:0] pid_o,
  output logic [10:0] field_o
);

  logic good_reg, good_next;
  logic sof_reg, sof_next;
  logic [3:0] pid_reg, pid_next;
  logic [10:0] field_reg, field_next;

  // CRC5 over the eleven field bits, first wire bit in bit 0.
  function automatic logic [4:0] crc5(input logic [10:0] data);
    logic [4:0] crc;
    logic fb;
    crc = 5'h1f;
    for (int i = 0; i < 11; i++) begin
      fb = data[i] ^ crc[4];
      crc = {crc[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    return ~crc;
  endfunction : crc5

  // --------------------------------------------------------------------
  // Decide whether the token is good; SOF carries no address.
  // --------------------------------------------------------------------
  always_comb begin
    logic pid_ok;
    logic crc_ok;
    pid_ok = (token_i.pid[3:0] == ~token_i.pid[7:4]);
    crc_ok = (crc5(token_i.field) == token_i.crc5);
    sof_next = token_valid_i && pid_ok && crc_ok && (token_i.pid[3:0] == USF_PID_SOF);
    good_next = token_valid_i && pid_ok && crc_ok && (token_i.pid[3:0] != USF_PID_SOF) &&
                (token_i.field[6:0] == dev_addr_i);
    pid_next = token_i.pid[3:0];
    field_next = token_i.field;
  end

  // Register the result.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      good_reg <= 1'b0;
      sof_reg <= 1'b0;
      pid_reg <= 4'h0;
      field_reg <= 11'h000;
    end else begin
      good_reg <= good_next;
      sof_reg <= sof_next;
      pid_reg <= pid_next;
      field_reg <= field_next;
    end
  end

  assign good_o = good_reg;
  assign sof_o = sof_reg;
  assign pid_o = pid_reg;
  assign field_o = field_reg;

endmodule : usf_token_check

// ===== usf_status_flag_unit.sv
// Status and flag unit: registers, flags and port masks.
`timescale 1ns/1ps

module usf_status_flag_unit
  import usf_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Peripheral register port.
  input wire usf_bus_req_type bus_req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // Programmed device address.
  input wire logic [6:0] dev_addr_i,
  // Transceiver status pins.
  input wire usf_otg_type otg_i,
  input wire logic rx_rcv_i,
  input wire logic rx_dm_i,
  input wire logic rx_dp_i,
  input wire logic [1:0] line_state_i,
  input wire logic rx_active_i,
  input wire logic rx_error_i,
  // Packet engine, same clock.
  input wire usf_token_type token_i,
  input wire logic token_valid_i,
  input wire logic data_pid_valid_i,
  input wire logic [3:0] data_pid_i,
  input wire logic crc16_fail_i,
  // Serial transmit controls to the transceiver.
  output logic tx_se0_o,
  output logic tx_data_o,
  output logic tx_enable_low_o,
  output logic serial_interface_select_o,
  // Flag ports towards the processor.
  output logic flag_port_n_o,
  output logic flag_port_o_o,
  output logic flag_port_p_o,
  output logic flag_port_q_o,
  // Endpoint delivered on the receive port.
  output logic [4:0] rx_endpoint_o,
  output logic rx_endpoint_valid_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisation.
  // ----------------------------------------------------------------------
  localparam int PIN_W = 13;

  logic [PIN_W-1:0] pins_sync; // Synchronised pin group.
  usf_otg_type otg_s; // Synchronised on-the-go inputs.
  logic rcv_s, dm_s, dp_s; // Synchronised serial receive lines.
  logic [1:0] ls_s; // Synchronised line state.
  logic act_s, err_s; // Synchronised receive-active and receive-error.

  usf_sync2 #(.WIDTH(PIN_W)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({otg_i, rx_rcv_i, rx_dm_i, rx_dp_i, line_state_i, rx_active_i, rx_error_i}),
    .sync_o(pins_sync)
  );

  assign {otg_s, rcv_s, dm_s, dp_s, ls_s, act_s, err_s} = pins_sync;

  // ----------------------------------------------------------------------
  // Token checking.
  // ----------------------------------------------------------------------
  logic tok_good; // Addressed token passed all checks.
  logic tok_sof; // Start-of-frame token passed its checks.
  logic [3:0] tok_pid; // Identifier of the checked token.
  logic [10:0] tok_field; // Address/endpoint or frame number field.

  usf_token_check u_token (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .token_i(token_i),
    .token_valid_i(token_valid_i),
    .dev_addr_i(dev_addr_i),
    .good_o(tok_good),
    .sof_o(tok_sof),
    .pid_o(tok_pid),
    .field_o(tok_field)
  );

  // ----------------------------------------------------------------------
  // State declarations.
  // ----------------------------------------------------------------------
  usf_regs_type regs_reg, regs_next; // Software-visible state.
  logic act_prev_reg, act_prev_next; // Receive-active one cycle ago.
  logic [31:0] rdata_reg, rdata_next; // Read data.
  logic rvalid_reg, rvalid_next; // Read answer strobe.
  logic [3:0] ports_reg, ports_next; // Flag ports Q, P, O, N.
  logic [4:0] rx_endp_reg, rx_endp_next; // Endpoint on the receive port.
  logic rx_endp_valid_reg, rx_endp_valid_next; // Receive port strobe.

  logic soft_reset; // Write to the reset register.
  logic pkt_start; // A new packet begins.
  logic [6:0] flag_src; // Current source value of each flag.
  logic [6:0] flag_clr; // Software write-one clear.

  // ----------------------------------------------------------------------
  // Shared event decode.
  // ----------------------------------------------------------------------
  always_comb begin
    soft_reset = bus_req_i.wr && (bus_req_i.addr == USF_OFS_RESET);
    pkt_start = act_s && !act_prev_reg;
    flag_clr = (bus_req_i.wr && (bus_req_i.addr == USF_OFS_FLAGS)) ?
               bus_req_i.wdata[6:0] : 7'h00;
    flag_src = '0;
    flag_src[USF_FLG_TOKEN] = tok_good;
    flag_src[USF_FLG_SE0] = (ls_s == USF_LS_SE0);
    flag_src[USF_FLG_K] = (ls_s == USF_LS_K);
    flag_src[USF_FLG_J] = (ls_s == USF_LS_J);
    flag_src[USF_FLG_CRC16] = crc16_fail_i;
    flag_src[USF_FLG_RXACT] = act_s;
    flag_src[USF_FLG_RXERR] = err_s;
  end

  // ----------------------------------------------------------------------
  // Next values of the register state.
  // ----------------------------------------------------------------------
  always_comb begin
    regs_next = regs_reg;
    act_prev_next = act_s;
    // Flags: a source that is high wins over a write-one clear or a packet start.
    for (int i = 0; i < USF_FLAG_W; i++) begin
      if (regs_reg.hold[i]) begin
        regs_next.flags[i] = (regs_reg.flags[i] && !flag_clr[i]) || flag_src[i];
      end else if (USF_FLG_LEVEL[i]) begin
        regs_next.flags[i] = flag_src[i];
      end else begin
        regs_next.flags[i] = (regs_reg.flags[i] && !flag_clr[i] && !pkt_start) ||
                             flag_src[i];
      end
    end
    // Packet identifier and endpoint capture.
    if (tok_good || tok_sof) begin
      regs_next.pid = tok_pid;
    end
    if (data_pid_valid_i) begin
      regs_next.pid = data_pid_i;
    end
    if (tok_good) begin
      regs_next.endp = tok_field[10:7];
      regs_next.endp_valid = 1'b1;
    end
    if (tok_sof) begin
      regs_next.frame = tok_field;
    end
    // Software writes; full 32-bit words only.
    if (bus_req_i.wr) begin
      case (bus_req_i.addr)
        USF_OFS_SERIAL: begin
          regs_next.ser_ctl = bus_req_i.wdata[USF_SER_CTL_W-1:0];
        end
        USF_OFS_HOLD: begin
          regs_next.hold = bus_req_i.wdata[6:0];
        end
        USF_OFS_MASKS: begin
          regs_next.masks = bus_req_i.wdata;
        end
        USF_OFS_FRAME: begin
          regs_next.frame = bus_req_i.wdata[USF_FRAME_W-1:0];
        end
        USF_OFS_SPECIAL: begin
          regs_next.special = bus_req_i.wdata[15:0];
        end
        USF_OFS_OTG_MASK: begin
          regs_next.otg_mask = bus_req_i.wdata;
        end
        USF_OFS_PWRSIG: begin
          regs_next.pwrsig = bus_req_i.wdata[USF_PWRSIG_W-1:0];
        end
        default: begin
          // Other words ignore writes here; flag clears and the reset write act elsewhere.
          regs_next.pwrsig = regs_next.pwrsig;
        end
      endcase
    end
    // A reset write overrides everything in the same cycle.
    if (soft_reset) begin
      regs_next = USF_REGS_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // Next values of the ports and the read answer.
  // ----------------------------------------------------------------------
  always_comb begin
    // Ports follow the stored flags, held or not, and masks.
    ports_next[0] = usf_any_flag(regs_reg.flags, regs_reg.masks[USF_MSK_N_LSB +: 8]);
    ports_next[1] = usf_any_flag(regs_reg.flags, regs_reg.masks[USF_MSK_O_LSB +: 8]);
    ports_next[2] = usf_any_flag(regs_reg.flags, regs_reg.masks[USF_MSK_P_LSB +: 8]);
    ports_next[3] = usf_any_flag(regs_reg.flags, regs_reg.masks[USF_MSK_Q_LSB +: 8]);
    // Endpoint delivery, special ones marked.
    rx_endp_valid_next = tok_good && !soft_reset;
    rx_endp_next = rx_endp_reg;
    if (tok_good) begin
      rx_endp_next = {1'b0, tok_field[10:7]} |
                     (regs_reg.special[tok_field[10:7]] ? USF_SPECIAL_OR : 5'h00);
    end
    if (soft_reset) begin
      rx_endp_next = 5'h00;
    end
    // Read data, one cycle after the request.
    rvalid_next = bus_req_i.rd;
    rdata_next = 32'h0000_0000;
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        USF_OFS_OTG_STATUS: begin
          rdata_next[5:0] = otg_s;
        end
        USF_OFS_SERIAL: begin
          rdata_next[6:0] = {rcv_s, dm_s, dp_s, regs_reg.ser_ctl};
        end
        USF_OFS_FLAGS: begin
          rdata_next[6:0] = regs_reg.flags;
        end
        USF_OFS_HOLD: begin
          rdata_next[6:0] = regs_reg.hold;
        end
        USF_OFS_MASKS: begin
          rdata_next = regs_reg.masks;
        end
        USF_OFS_FRAME: begin
          rdata_next[USF_FRAME_W-1:0] = regs_reg.frame;
        end
        USF_OFS_PID: begin
          rdata_next[3:0] = regs_reg.pid;
        end
        USF_OFS_ENDPOINT: begin
          rdata_next[USF_ENDP_VALID:0] = {regs_reg.endp_valid, regs_reg.endp};
        end
        USF_OFS_SPECIAL: begin
          rdata_next[15:0] = regs_reg.special;
        end
        USF_OFS_OTG_MASK: begin
          rdata_next = regs_reg.otg_mask;
        end
        USF_OFS_PWRSIG: begin
          rdata_next[USF_PWRSIG_W-1:0] = regs_reg.pwrsig;
        end
        default: begin
          // Unmapped words read as zero.
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      regs_reg <= USF_REGS_RESET;
      act_prev_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      ports_reg <= 4'h0;
      rx_endp_reg <= 5'h00;
      rx_endp_valid_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      act_prev_reg <= act_prev_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      ports_reg <= ports_next;
      rx_endp_reg <= rx_endp_next;
      rx_endp_valid_reg <= rx_endp_valid_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, each straight from a flip-flop.
  // ----------------------------------------------------------------------
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign tx_se0_o = regs_reg.ser_ctl[USF_SER_TXSE0];
  assign tx_data_o = regs_reg.ser_ctl[USF_SER_TXDAT];
  assign tx_enable_low_o = regs_reg.ser_ctl[USF_SER_TXENN];
  assign serial_interface_select_o = regs_reg.ser_ctl[USF_SER_FSLS];
  assign flag_port_n_o = ports_reg[0];
  assign flag_port_o_o = ports_reg[1];
  assign flag_port_p_o = ports_reg[2];
  assign flag_port_q_o = ports_reg[3];
  assign rx_endpoint_o = rx_endp_reg;
  assign rx_endpoint_valid_o = rx_endp_valid_reg;

endmodule : usf_status_flag_unit

// ===== usf_assertions.sv
// Port-level checker for the status and flag unit.
`timescale 1ns/1ps

module usf_chk
  import usf_pkg::*;
(
  // Clock, reset and register port.
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire usf_bus_req_type bus_req_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  // Outputs watched.
  input wire logic tx_se0_o,
  input wire logic tx_data_o,
  input wire logic tx_enable_low_o,
  input wire logic serial_interface_select_o,
  input wire logic flag_port_n_o,
  input wire logic flag_port_q_o,
  input wire logic [4:0] rx_endpoint_o,
  input wire logic rx_endpoint_valid_o
);
  // ---------------------------------------------------------------
  // Clocking and helpers.
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Writes to the serial and soft reset words.
  logic ser_wr;
  logic soft_wr;
  assign ser_wr = bus_req_i.wr && (bus_req_i.addr == USF_OFS_SERIAL);
  assign soft_wr = bus_req_i.wr && (bus_req_i.addr == USF_OFS_RESET);

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  rd_answer_a: assert property (bus_req_i.rd |=> rvalid_o)
    else $error("read not answered");
  idle_data_a: assert property (!rvalid_o |-> rdata_o == 32'h0)
    else $error("idle read data not zero");
  otg_reserved_a: assert property (bus_req_i.rd && bus_req_i.addr == USF_OFS_OTG_STATUS
    |=> rdata_o[31:6] == 26'h0) else $error("status reserved bits set");
  ser_read_a: assert property (bus_req_i.rd && !bus_req_i.wr && bus_req_i.addr == USF_OFS_SERIAL
    |=> rdata_o[3:0] == {tx_se0_o, tx_data_o, tx_enable_low_o, serial_interface_select_o}
    && rdata_o[31:7] == 25'h0) else $error("serial word wrong");
  se0_write_a: assert property (ser_wr |=> tx_se0_o == $past(bus_req_i.wdata[3])
    && tx_data_o == $past(bus_req_i.wdata[2])) else $error("tx bits not written");
  ten_write_a: assert property (ser_wr |=> tx_enable_low_o == $past(bus_req_i.wdata[1]))
    else $error("tx enable not written");
  ten_hold_a: assert property (!ser_wr && !soft_wr |=> $stable(tx_enable_low_o))
    else $error("tx enable moved");
  fsls_write_a: assert property (ser_wr |=> serial_interface_select_o == $past(bus_req_i.wdata[0]))
    else $error("select not written");
  soft_reset_a: assert property (soft_wr |=> tx_enable_low_o && !tx_se0_o && !tx_data_o)
    else $error("soft reset missed");
  reset_state_a: assert property ($fell(rst_i) |-> tx_enable_low_o && !flag_port_n_o
    && !serial_interface_select_o) else $error("wrong after reset");

  // Main scenarios seen.
  cover property (ser_wr && !bus_req_i.wdata[1]);
  cover property (rx_endpoint_valid_o && rx_endpoint_o[4]);
  cover property (flag_port_q_o);
endmodule : usf_chk

bind usf_status_flag_unit usf_chk u_chk (.core_clk_i, .rst_i, .bus_req_i, .rdata_o, .rvalid_o,
  .tx_se0_o, .tx_data_o, .tx_enable_low_o, .serial_interface_select_o, .flag_port_n_o,
  .flag_port_q_o, .rx_endpoint_o, .rx_endpoint_valid_o);

// ===== usf_xcvr_model.sv
// Behavioural transceiver driving status pins and line state.
`timescale 1ns/1ps

module usf_xcvr_model
  import usf_pkg::*;
(
  // Core clock.
  input wire logic core_clk_i,
  // Serial transmit controls from the unit.
  input wire logic tx_se0_i,
  input wire logic tx_data_i,
  input wire logic tx_enable_low_i,
  // Status pins towards the unit.
  output usf_otg_type otg_o,
  output logic rx_rcv_o,
  output logic rx_dm_o,
  output logic rx_dp_o,
  output logic [1:0] line_state_o,
  output logic rx_active_o,
  output logic rx_error_o
);
  // Idle line state.
  logic [1:0] idle_ls = USF_LS_J;

  // All status pins except the line state start low.
  initial begin
    otg_o = '0;
    {rx_rcv_o, rx_dm_o, rx_dp_o, rx_active_o, rx_error_o} = 5'h00;
  end

  // While transmitting, the line shows what the unit sends.
  assign line_state_o = tx_enable_low_i ? idle_ls :
    (tx_se0_i ? USF_LS_SE0 : (tx_data_i ? USF_LS_J : USF_LS_K));

  // Changes the pins just after a clock edge.
  task automatic set_pins(input usf_otg_type otg, input logic [2:0] rx, input logic act,
    input logic err);
    @(posedge core_clk_i);
    otg_o <= otg;
    {rx_rcv_o, rx_dm_o, rx_dp_o} <= rx;
    rx_active_o <= act;
    rx_error_o <= err;
  endtask : set_pins
endmodule : usf_xcvr_model

// ===== test_usb_utmi_status_flag_unit.sv
// Self-checking bench for the status and flag unit.
`timescale 1ns/1ps

module test_usb_utmi_status_flag_unit import usf_pkg::*;;
  // ---------------------------------------------------------------
  // Signals and counters.
  // ---------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  usf_bus_req_type bus_req_i = '0;
  logic [6:0] dev_addr_i = 7'h05;
  usf_token_type token_i = '0;
  logic token_valid_i = 1'b0;
  logic data_pid_valid_i = 1'b0;
  logic [3:0] data_pid_i = 4'h0;
  logic crc16_fail_i = 1'b0;
  logic [31:0] rdata_o;
  logic rvalid_o, tx_se0_o, tx_data_o, tx_enable_low_o, serial_interface_select_o;
  logic flag_port_n_o, flag_port_o_o, flag_port_p_o, flag_port_q_o, rx_endpoint_valid_o;
  logic [4:0] rx_endpoint_o;
  usf_otg_type otg_i;
  logic rx_rcv_i, rx_dm_i, rx_dp_i, rx_active_i, rx_error_i;
  logic [1:0] line_state_i;
  int n_mismatch = 0;
  int num_checks = 0;
  // Reset values of the writable words other than the OTG mask.
  logic [7:0] rst_addr [6] = '{USF_OFS_SERIAL, USF_OFS_HOLD, USF_OFS_MASKS, USF_OFS_FRAME,
    USF_OFS_SPECIAL, USF_OFS_PWRSIG};
  logic [31:0] rst_val [6] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  // Serial words for SE0, K, J and their flags.
  logic [31:0] ser_v [3] = '{32'h9, 32'h1, 32'h5};
  logic [31:0] flg_v [3] = '{32'h20, 32'h10, 32'h08};

  always #12.5 core_clk_i = ~core_clk_i;

  usf_status_flag_unit uut (.*);
  usf_xcvr_model xcvr (.core_clk_i(core_clk_i), .tx_se0_i(tx_se0_o), .tx_data_i(tx_data_o),
    .tx_enable_low_i(tx_enable_low_o), .otg_o(otg_i), .rx_rcv_o(rx_rcv_i), .rx_dm_o(rx_dm_i),
    .rx_dp_o(rx_dp_i), .line_state_o(line_state_i), .rx_active_o(rx_active_i),
    .rx_error_o(rx_error_i));

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  // Compares and counts.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Waits n edges plus 1 ns.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  // One access; a read checks its answer.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus_req_i <= '0;
    #1;
    if (!w) chk($sformatf("word %h", a), rdata_o, d);
  endtask : acc

  // CRC5, low field bit first.
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 0; i < 11; i++) c = {c[3:0], 1'b0} ^ ((d[i] ^ c[4]) ? 5'h05 : 5'h00);
    return ~c;
  endfunction : crc5

  // Sends one token, maybe with a bad CRC5; returns while the endpoint pulse stands.
  task automatic tok(input logic [10:0] f, input logic bad);
    @(posedge core_clk_i);
    token_i <= '{pid: 8'he1, field: f, crc5: crc5(f) ^ {4'h0, bad}};
    token_valid_i <= 1'b1;
    @(posedge core_clk_i);
    token_valid_i <= 1'b0;
    tick(1);
  endtask : tok

  // Prints counts and verdict, then stops.
  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    foreach (rst_addr[i]) acc(1'b0, rst_addr[i], rst_val[i]);
    xcvr.set_pins(6'h2b, 3'b101, 1'b0, 1'b0);
    tick(4);
    acc(1'b1, USF_OFS_OTG_STATUS, 32'hffff_ffff);
    acc(1'b0, USF_OFS_OTG_STATUS, 32'h2b);
    acc(1'b0, USF_OFS_SERIAL, 32'h52);
    // Each line symbol sets its own flag.
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, USF_OFS_SERIAL, ser_v[i]);
      chk("tx", {tx_se0_o, tx_data_o, tx_enable_low_o, serial_interface_select_o}, ser_v[i]);
      tick(4);
      acc(1'b0, USF_OFS_FLAGS, flg_v[i]);
    end
    // A held SE0 flag stays until written 1.
    acc(1'b1, USF_OFS_HOLD, 32'h20);
    acc(1'b1, USF_OFS_SERIAL, 32'h9);
    tick(4);
    acc(1'b1, USF_OFS_SERIAL, 32'h2);
    tick(4);
    acc(1'b0, USF_OFS_FLAGS, 32'h28);
    acc(1'b1, USF_OFS_FLAGS, 32'h20);
    acc(1'b0, USF_OFS_FLAGS, 32'h08);
    acc(1'b1, USF_OFS_MASKS, 32'h4008_0008);
    tick(2);
    chk("ports", {flag_port_q_o, flag_port_p_o, flag_port_o_o, flag_port_n_o}, 4'h5);
    // Good token, special endpoint; then bad ones.
    acc(1'b1, USF_OFS_SPECIAL, 32'h8);
    tok({4'h3, 7'h05}, 1'b0);
    chk("endpoint", {rx_endpoint_valid_o, rx_endpoint_o}, 32'h33);
    tick(1);
    chk("port q", flag_port_q_o, 32'h1);
    acc(1'b0, USF_OFS_FLAGS, 32'h48);
    acc(1'b0, USF_OFS_ENDPOINT, 32'h13);
    acc(1'b0, USF_OFS_PID, 32'h1);
    acc(1'b1, USF_OFS_FLAGS, 32'h40);
    tok({4'h3, 7'h05}, 1'b1);
    tok({4'h3, 7'h06}, 1'b0);
    acc(1'b0, USF_OFS_FLAGS, 32'h08);
    // CRC16 failure, cleared by a packet start.
    @(posedge core_clk_i);
    crc16_fail_i <= 1'b1;
    @(posedge core_clk_i);
    crc16_fail_i <= 1'b0;
    tick(1);
    acc(1'b0, USF_OFS_FLAGS, 32'h0c);
    xcvr.set_pins(6'h2b, 3'b101, 1'b1, 1'b0);
    tick(4);
    acc(1'b0, USF_OFS_FLAGS, 32'h0a);
    xcvr.set_pins(6'h2b, 3'b101, 1'b1, 1'b1);
    tick(4);
    acc(1'b0, USF_OFS_FLAGS, 32'h0b);
    acc(1'b1, USF_OFS_FRAME, 32'hffff_ffff);
    acc(1'b0, USF_OFS_FRAME, 32'h7ff);
    acc(1'b1, USF_OFS_RESET, 32'h1234_5678);
    acc(1'b0, USF_OFS_FRAME, 32'h0);
    acc(1'b0, USF_OFS_HOLD, 32'h0);
    acc(1'b0, 8'h44, 32'h0);
    close_out();
  end

  // Cuts a hang short.
  initial begin
    repeat (4000) @(posedge core_clk_i);
    n_mismatch++;
    close_out();
  end
endmodule : test_usb_utmi_status_flag_unit
